// [verilog/mste_defines.svh]
// Constants for the memory self-test engine: CRC figures, access widths,
// march data patterns. Included by the package users; holds definitions only.
`ifndef MSTE_DEFINES_SVH
`define MSTE_DEFINES_SVH

// Checksum engine
`define MSTE_CRC_POLY  16'h1021
`define MSTE_CRC_INIT  16'hFFFF
`define MSTE_CRC_XOR   16'hFFFF

// Access width codes on cmd_width and mem_size
`define MSTE_W8        2'h0
`define MSTE_W16       2'h1
`define MSTE_W32       2'h2

// March data pattern codes
`define MSTE_PAT_ZERO  2'h0
`define MSTE_PAT_ONES  2'h1
`define MSTE_PAT_AA    2'h2
`define MSTE_PAT_55    2'h3

// March data pattern values, cut to the access width in use
`define MSTE_VAL_ZERO  32'h0000_0000
`define MSTE_VAL_ONES  32'hFFFF_FFFF
`define MSTE_VAL_AA    32'hAAAA_AAAA
`define MSTE_VAL_55    32'h5555_5555

// Last march element index (six elements)
`define MSTE_LAST_ELEM 3'h5

`endif

// [verilog/mste_pkg.sv]
// Types shared by the memory self-test engine and its users.
// Assumes nothing of its surroundings.
package mste_pkg;

  typedef enum logic [2:0] {
    OP_INIT, OP_START, OP_ACCUM, OP_RESULT, OP_VERIFY, OP_ROMCHK, OP_MARCH
  } mste_op_e;

  typedef enum logic {
    ALG_MARCH_C, ALG_MARCH_X
  } mste_alg_e;

  typedef enum logic [1:0] {
    PH_SAFE, PH_SAVE, PH_MARCH, PH_RESTORE
  } mste_phase_e;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CRC_RD, ST_CRC_WT, ST_REF_RD, ST_REF_WT, ST_PHASE, ST_EL_START,
    ST_M_RD, ST_M_WT, ST_M_WR, ST_M_NEXT, ST_PH_END, ST_CP_RD, ST_CP_WT,
    ST_CP_WR, ST_FIN
  } mste_state_e;

endpackage

// [verilog/mste_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; in_ready is registered so it may leave the block.
`timescale 1ns/1ps
module mste_buf2 #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem [2];
  logic         wp;
  logic         rp;
  logic [1:0]   count;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count    <= 2'h0;
      wp       <= 1'b0;
      rp       <= 1'b0;
      in_ready <= 1'b1;
    end else begin
      count    <= next_count;
      in_ready <= (next_count != 2'h2);
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// [verilog/mste_top.sv]
// Memory self-test engine: CRC-16 check of read-only memory and
// March C / word-oriented March X test of RAM with optional save/restore.
// Assumes a memory port on the same clock that accepts one request per
// req/gnt pair and returns read data later on mem_rvalid.
// Notes on behaviour
// - Checksum is CRC-16 with generator 0x1021, bitwise modulo two.
// - Shift register preset to all ones at each checksum start.
// - Result is the register inverted with all ones.
// - Input is read a byte at a time from start address for a byte count.
// - Start once, add each range, then ask result; state kept across ranges.
// - Result covers all bytes of all ranges added since the last start.
// - Verify reads stored 16-bit reference and passes only when equal.
// - ROM check recalculates checksum and compares with saved reference.
// - March C has six elements and ten operations.
// - March C: w0; up r0w1; up r1w0; down r0w1; down r1w0; r0.
// - March X uses access-width patterns and steps word by word.
// - March X: w0; up r0 w1s; down r1s w0.
// - March X then: up r0 wAA; down rAA w55; read 55 everywhere.
// - Non-destructive run saves area to buffer first and restores after.
// - Save buffer may itself be march tested before use.
// - Failed buffer test aborts before target is touched, reports fail.
// - Width 8, 16 or 32; addresses aligned; end not below start.
`timescale 1ns/1ps
`include "mste_defines.svh"
module mste_top
  import mste_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Command
  input  wire logic        cmd_valid,
  input  wire mste_op_e    cmd_op,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [31:0] cmd_len,
  input  wire logic [31:0] cmd_end,
  input  wire logic [31:0] cmd_safe,
  input  wire logic [31:0] cmd_ref_addr,
  input  wire logic [1:0]  cmd_width,
  input  wire mste_alg_e   cmd_alg,
  input  wire logic        cmd_nondestr,
  input  wire logic        cmd_test_safe,
  // Status
  output logic             busy,
  output logic             done,
  output logic             pass,
  output logic [15:0]      crc_result,
  // Memory port
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_size,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_gnt,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata,
  output logic             mem_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0} ^ (fb ? `MSTE_CRC_POLY : 16'h0000);
    end
    return r;
  endfunction

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    case (w)
      `MSTE_W8:  return 32'h0000_00FF;
      `MSTE_W16: return 32'h0000_FFFF;
      default:   return 32'hFFFF_FFFF;
    endcase
  endfunction

  function automatic logic [31:0] pat_val(input logic [1:0] p, input logic [1:0] w);
    logic [31:0] v;
    case (p)
      `MSTE_PAT_ZERO: v = `MSTE_VAL_ZERO;
      `MSTE_PAT_ONES: v = `MSTE_VAL_ONES;
      `MSTE_PAT_AA:   v = `MSTE_VAL_AA;
      default:        v = `MSTE_VAL_55;
    endcase
    return v & width_mask(w);
  endfunction

  // Element: {read, read pattern, write, write pattern, descending}
  function automatic logic [6:0] elem_info(input mste_alg_e a, input logic [2:0] e);
    logic x;
    x = (a == ALG_MARCH_X);
    case (e)
      3'h0: return {1'b0, `MSTE_PAT_ZERO, 1'b1, `MSTE_PAT_ZERO, 1'b0};
      3'h1: return {1'b1, `MSTE_PAT_ZERO, 1'b1, `MSTE_PAT_ONES, 1'b0};
      3'h2: return {1'b1, `MSTE_PAT_ONES, 1'b1, `MSTE_PAT_ZERO, x};
      3'h3: return x ? {1'b1, `MSTE_PAT_ZERO, 1'b1, `MSTE_PAT_AA, 1'b0}
                     : {1'b1, `MSTE_PAT_ZERO, 1'b1, `MSTE_PAT_ONES, 1'b1};
      3'h4: return x ? {1'b1, `MSTE_PAT_AA, 1'b1, `MSTE_PAT_55, 1'b1}
                     : {1'b1, `MSTE_PAT_ONES, 1'b1, `MSTE_PAT_ZERO, 1'b1};
      default: return x ? {1'b1, `MSTE_PAT_55, 1'b0, `MSTE_PAT_ZERO, 1'b0}
                        : {1'b1, `MSTE_PAT_ZERO, 1'b0, `MSTE_PAT_ZERO, 1'b0};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  mste_state_e state;
  mste_phase_e phase;
  mste_op_e    op_q;
  mste_alg_e   alg_q;
  logic [15:0] crc;
  logic [15:0] refv;
  logic        inited;
  logic        fail;
  logic [1:0]  width_q;
  logic        nondestr_q;
  logic        tsafe_q;
  logic [31:0] start_q;
  logic [31:0] safe_q;
  logic [31:0] ref_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic [31:0] span;
  logic [31:0] off;
  logic [31:0] remain;
  logic [2:0]  elem;
  logic [31:0] cp_data;

  logic        buf_ovalid;
  logic [31:0] buf_odata;
  logic        buf_ordy;
  logic [6:0]  einfo;
  logic [31:0] step;
  logic [31:0] rd_masked;
  logic        mismatch;
  logic        el_last;
  logic        accept;
  logic        args_ok;

  assign accept    = (state == ST_IDLE) && cmd_valid;
  assign einfo     = elem_info(alg_q, elem);
  assign step      = 32'h0000_0001 << width_q;
  assign rd_masked = buf_odata & width_mask(width_q);
  assign mismatch  = (rd_masked != pat_val(einfo[5:4], width_q));
  assign el_last   = einfo[0] ? (off == 32'h0000_0000) : (off == span);
  assign buf_ordy  = (state == ST_CRC_WT) || (state == ST_REF_WT) ||
                     (state == ST_M_WT) || (state == ST_CP_WT);

  // Width legal, every address aligned, end not below start
  always_comb begin
    logic [31:0] am;
    am      = (cmd_width == `MSTE_W16) ? 32'h0000_0001 :
              (cmd_width == `MSTE_W32) ? 32'h0000_0003 : 32'h0000_0000;
    args_ok = (cmd_width != 2'h3) && ((cmd_addr & am) == 32'h0000_0000) &&
              ((cmd_end & am) == 32'h0000_0000) && (cmd_end >= cmd_addr) &&
              (!cmd_nondestr || ((cmd_safe & am) == 32'h0000_0000));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data buffer: a stalled consumer never loses a returned word

  mste_buf2 #(.W(32)) u_rbuf (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .in_valid  (mem_rvalid),
    .in_ready  (mem_rready),
    .in_data   (mem_rdata),
    .out_valid (buf_ovalid),
    .out_data  (buf_odata),
    .out_ready (buf_ordy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checksum register

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc <= `MSTE_CRC_INIT;
    end else if (accept && inited && (cmd_op == OP_START || cmd_op == OP_ROMCHK)) begin
      crc <= `MSTE_CRC_INIT;
    end else if (state == ST_CRC_WT && buf_ovalid) begin
      crc <= crc_byte(crc, buf_odata[7:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and memory port

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;      phase <= PH_MARCH;   op_q <= OP_INIT;
      alg_q <= ALG_MARCH_C;  inited <= 1'b0;      fail <= 1'b0;
      width_q <= `MSTE_W8;   nondestr_q <= 1'b0;  tsafe_q <= 1'b0;
      start_q <= '0;  safe_q <= '0;  ref_q <= '0;  src_q <= '0;  dst_q <= '0;
      span <= '0;  off <= '0;  remain <= '0;  elem <= 3'h0;  cp_data <= '0;
      refv <= 16'h0000;
      busy <= 1'b0;  done <= 1'b0;  pass <= 1'b0;  crc_result <= 16'h0000;
      mem_req <= 1'b0;  mem_we <= 1'b0;  mem_size <= `MSTE_W8;
      mem_addr <= '0;   mem_wdata <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            busy <= 1'b1;
            op_q <= cmd_op;
            fail <= 1'b0;
            src_q <= cmd_addr;
            off <= '0;
            remain <= cmd_len;
            ref_q <= cmd_ref_addr;
            state <= ST_FIN;
            if (cmd_op == OP_INIT) begin
              inited <= 1'b1;
            end else if (cmd_op == OP_MARCH) begin
              alg_q <= cmd_alg;  width_q <= cmd_width;  start_q <= cmd_addr;
              safe_q <= cmd_safe;  nondestr_q <= cmd_nondestr;
              tsafe_q <= cmd_test_safe;  span <= cmd_end - cmd_addr;
              phase <= (cmd_nondestr && cmd_test_safe) ? PH_SAFE :
                       cmd_nondestr ? PH_SAVE : PH_MARCH;
              if (args_ok) begin
                state <= ST_PHASE;
              end else begin
                fail <= 1'b1;
              end
            end else if (!inited) begin
              fail <= 1'b1;
            end else if (cmd_op == OP_ACCUM || cmd_op == OP_ROMCHK) begin
              state <= (cmd_len == 32'h0000_0000) ?
                       ((cmd_op == OP_ROMCHK) ? ST_REF_RD : ST_FIN) : ST_CRC_RD;
            end else if (cmd_op == OP_VERIFY) begin
              state <= ST_REF_RD;
            end
          end
        end
        ST_CRC_RD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b0;  mem_size <= `MSTE_W8;
            mem_addr <= src_q + off;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            state <= ST_CRC_WT;
          end
        end
        ST_CRC_WT: begin
          if (buf_ovalid) begin
            off <= off + 32'h0000_0001;
            remain <= remain - 32'h0000_0001;
            if (remain == 32'h0000_0001) begin
              state <= (op_q == OP_ROMCHK) ? ST_REF_RD : ST_FIN;
            end else begin
              state <= ST_CRC_RD;
            end
          end
        end
        ST_REF_RD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b0;  mem_size <= `MSTE_W16;
            mem_addr <= ref_q;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            state <= ST_REF_WT;
          end
        end
        ST_REF_WT: begin
          if (buf_ovalid) begin
            refv <= buf_odata[15:0];
            fail <= (buf_odata[15:0] != (crc ^ `MSTE_CRC_XOR));
            state <= ST_FIN;
          end
        end
        ST_PHASE: begin
          off <= '0;
          elem <= 3'h0;
          case (phase)
            PH_SAFE:  begin src_q <= safe_q;  state <= ST_EL_START; end
            PH_SAVE:  begin src_q <= start_q; dst_q <= safe_q;  state <= ST_CP_RD; end
            PH_MARCH: begin src_q <= start_q; state <= ST_EL_START; end
            default:  begin src_q <= safe_q;  dst_q <= start_q; state <= ST_CP_RD; end
          endcase
        end
        ST_EL_START: begin
          off <= einfo[0] ? span : 32'h0000_0000;
          state <= einfo[6] ? ST_M_RD : ST_M_WR;
        end
        ST_M_RD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b0;  mem_size <= width_q;
            mem_addr <= src_q + off;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            state <= ST_M_WT;
          end
        end
        ST_M_WT: begin
          if (buf_ovalid) begin
            if (mismatch) begin
              fail <= 1'b1;
            end
            state <= einfo[3] ? ST_M_WR : ST_M_NEXT;
          end
        end
        ST_M_WR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b1;  mem_size <= width_q;
            mem_addr <= src_q + off;
            mem_wdata <= pat_val(einfo[2:1], width_q);
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= ST_M_NEXT;
          end
        end
        ST_M_NEXT: begin
          if (el_last) begin
            if (elem == `MSTE_LAST_ELEM) begin
              state <= ST_PH_END;
            end else begin
              elem <= elem + 3'h1;
              state <= ST_EL_START;
            end
          end else begin
            off <= einfo[0] ? (off - step) : (off + step);
            state <= einfo[6] ? ST_M_RD : ST_M_WR;
          end
        end
        ST_PH_END: begin
          state <= ST_PHASE;
          case (phase)
            PH_SAFE: begin
              if (fail) begin
                state <= ST_FIN;
              end else begin
                phase <= PH_SAVE;
              end
            end
            PH_SAVE:  phase <= PH_MARCH;
            PH_MARCH: begin
              if (nondestr_q) begin
                phase <= PH_RESTORE;
              end else begin
                state <= ST_FIN;
              end
            end
            default:  state <= ST_FIN;
          endcase
        end
        ST_CP_RD: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b0;  mem_size <= width_q;
            mem_addr <= src_q + off;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            state <= ST_CP_WT;
          end
        end
        ST_CP_WT: begin
          if (buf_ovalid) begin
            cp_data <= rd_masked;
            state <= ST_CP_WR;
          end
        end
        ST_CP_WR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;  mem_we <= 1'b1;  mem_size <= width_q;
            mem_addr <= dst_q + off;
            mem_wdata <= cp_data;
          end else if (mem_gnt) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            off <= off + step;
            state <= (off == span) ? ST_PH_END : ST_CP_RD;
          end
        end
        ST_FIN: begin
          busy <= 1'b0;
          done <= 1'b1;
          pass <= !fail;
          if (inited && (op_q == OP_RESULT || op_q == OP_VERIFY || op_q == OP_ROMCHK)) begin
            crc_result <= crc ^ `MSTE_CRC_XOR;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_start_taken;
    accept && inited && (cmd_op == OP_START);
  endsequence

  sequence s_crc_byte_in;
    (state == ST_CRC_WT) && buf_ovalid;
  endsequence

  property p_crc_preset;
    @(posedge sys_clk) disable iff (sys_rst) s_start_taken |=> (crc == 16'hFFFF);
  endproperty
  a_crc_preset: assert property (p_crc_preset) else $error("crc not preset");

  property p_crc_step;
    @(posedge sys_clk) disable iff (sys_rst)
      s_crc_byte_in |=> (crc == crc_byte($past(crc), $past(buf_odata[7:0])));
  endproperty
  a_crc_step: assert property (p_crc_step) else $error("crc byte update wrong");

  property p_result_inv;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_FIN) && inited && (op_q == OP_RESULT) |=> done && (crc_result == ~crc);
  endproperty
  a_result_inv: assert property (p_result_inv) else $error("result not inverted");

  property p_crc_byte_rd;
    @(posedge sys_clk) disable iff (sys_rst)
      mem_req && (state == ST_CRC_RD) |-> (mem_size == 2'h0) && !mem_we;
  endproperty
  a_crc_byte_rd: assert property (p_crc_byte_rd) else $error("crc read not byte");

  property p_verify;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_REF_WT) && buf_ovalid ##1 (state == ST_FIN)
        |=> done && (pass == ($past(refv) == ($past(crc) ^ 16'hFFFF)));
  endproperty
  a_verify: assert property (p_verify) else $error("verify verdict wrong");

  property p_elem_range;
    @(posedge sys_clk) disable iff (sys_rst) elem <= 3'h5;
  endproperty
  a_elem_range: assert property (p_elem_range) else $error("too many elements");

  property p_first_w0;
    @(posedge sys_clk) disable iff (sys_rst)
      mem_req && mem_we && (state == ST_M_WR) && (elem == 3'h0) |-> (mem_wdata == 32'h0);
  endproperty
  a_first_w0: assert property (p_first_w0) else $error("first element not zeros");

  property p_x_aa;
    @(posedge sys_clk) disable iff (sys_rst)
      mem_req && mem_we && (state == ST_M_WR) && (alg_q == ALG_MARCH_X) && (elem == 3'h3)
        |-> (mem_wdata == (32'hAAAA_AAAA & width_mask(width_q)));
  endproperty
  a_x_aa: assert property (p_x_aa) else $error("march x alternating pattern wrong");

  property p_width;
    @(posedge sys_clk) disable iff (sys_rst)
      mem_req && (state inside {ST_M_RD, ST_M_WR, ST_CP_RD, ST_CP_WR}) |-> (mem_size == width_q);
  endproperty
  a_width: assert property (p_width) else $error("access width wrong");

  property p_mismatch;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_M_WT) && buf_ovalid && mismatch |=> fail;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not recorded");

  property p_abort;
    @(posedge sys_clk) disable iff (sys_rst)
      (state == ST_PH_END) && (phase == PH_SAFE) && fail |=> (state == ST_FIN) ##1 done && !pass;
  endproperty
  a_abort: assert property (p_abort) else $error("buffer failure not aborted");

  property p_done;
    @(posedge sys_clk) disable iff (sys_rst) done |-> !busy && $past(busy);
  endproperty
  a_done: assert property (p_done) else $error("done without busy");
endmodule

// [tb/mste_mem_model.sv]
// Memory model for the far side of the self-test engine's memory port.
// Assumes the engine's clock; the bench loads and inspects the array.
`timescale 1ns/1ps
module mste_mem_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Engine side
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [1:0]  mem_size,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_gnt,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata,
  input  wire logic        mem_rready,
  // Scenario controls
  input  wire logic        slow,
  input  wire logic [7:0]  fault_addr
);
  // Only the engine's port reaches the array during a run
  logic [7:0] mem [0:255];
  logic       odd;
  logic [7:0] a;
  assign a = mem_addr[7:0];
  // Slow mode grants only every other cycle
  assign mem_gnt = mem_req && !(slow && odd);
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      odd <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      odd <= !odd;
      // Released data shows the inverse, never the stale word
      if (mem_rvalid && mem_rready) begin
        mem_rvalid <= 1'b0;
        mem_rdata <= ~mem_rdata;
      end
      if (mem_gnt && mem_we) begin
        for (int i = 0; i < (1 << mem_size); i++) mem[8'(a + i)] <= mem_wdata[8*i +: 8];
      end else if (mem_gnt) begin
        mem_rvalid <= 1'b1;
        // Bit 0 of the faulty byte reads as 0 only when it is the addressed (lowest) byte of the read
        mem_rdata <= {mem[a+3], mem[a+2], mem[a+1], mem[a] & ~{7'h00, a == fault_addr}}
                     & ~(32'hFFFF_FFFF << (8 << mem_size));
      end
    end
  end
endmodule

// [tb/memory_self_test_engine_test.sv]
// Self-checking bench for the memory self-test engine.
// Assumes the memory model answers on the engine's memory port.
`timescale 1ns/1ps
module memory_self_test_engine_test
  import mste_pkg::*;
;
  localparam logic [31:0] REF = 32'h0000_0040;
  logic        sys_clk, sys_rst, cmd_valid, cmd_nondestr, cmd_test_safe, slow;
  mste_op_e    cmd_op;
  mste_alg_e   cmd_alg;
  logic [31:0] cmd_addr, cmd_len, cmd_end, cmd_safe, cmd_ref_addr, mem_addr, mem_wdata;
  logic [31:0] mem_rdata;
  logic [1:0]  cmd_width, mem_size;
  logic [15:0] crc_result, c;
  logic [7:0]  fault_addr;
  logic        busy, done, pass, mem_req, mem_we, mem_gnt, mem_rvalid, mem_rready;
  int          n_mismatch, compares;
  // Start, length, corrupt reference, expected pass
  int          rows [4][4] = '{'{0, 1, 0, 1}, '{3, 16, 0, 1}, '{8, 5, 1, 0}, '{0, 64, 0, 1}};

  mste_top mste_top_i (.sys_clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_len, .cmd_end,
    .cmd_safe, .cmd_ref_addr, .cmd_width, .cmd_alg, .cmd_nondestr, .cmd_test_safe, .busy, .done,
    .pass, .crc_result, .mem_req, .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_gnt,
    .mem_rvalid, .mem_rdata, .mem_rready);
  mste_mem_model mste_mem_model_i (.sys_clk, .sys_rst, .mem_req, .mem_we, .mem_size, .mem_addr,
    .mem_wdata, .mem_gnt, .mem_rvalid, .mem_rdata, .mem_rready, .slow, .fault_addr);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = !sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic do_reset;
    sys_rst = 1'b1;
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'b0;
  endtask

  task automatic run(input mste_op_e op, input logic [31:0] a, input logic [31:0] l,
                     input logic [1:0] w, input mste_alg_e alg, input logic [1:0] nd);
    int n;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_len = l;
    cmd_end = l;
    cmd_width = w;
    cmd_alg = alg;
    {cmd_nondestr, cmd_test_safe} = nd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk(busy, 1);
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20000) begin
      n_mismatch++;
      test_done;
    end
  endtask

  function automatic logic [15:0] crc_of(input int a, input int n, input logic [15:0] c);
    for (int i = a; i < a + n; i++) begin
      c ^= {mste_mem_model_i.mem[i], 8'h00};
      for (int b = 0; b < 8; b++) c = c[15] ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // Nonzero where the 16 target bytes differ from x, or from the fill pattern
  function automatic logic [7:0] diff(input logic [7:0] x, input bit p);
    logic [7:0] d;
    d = 8'h00;
    for (int i = 128; i < 144; i++) d |= mste_mem_model_i.mem[i] ^ (p ? 8'(i * 5 + 1) : x);
    return d;
  endfunction

  initial begin
    {cmd_valid, cmd_nondestr, cmd_test_safe, slow, cmd_width} = 6'h00;
    {cmd_addr, cmd_len, cmd_end} = 96'h0;
    {cmd_safe, cmd_ref_addr, fault_addr} = {32'h0000_00C0, REF, 8'hFF};
    cmd_op = OP_INIT;
    cmd_alg = ALG_MARCH_C;
    n_mismatch = 0;
    compares = 0;
    for (int i = 0; i < 256; i++) mste_mem_model_i.mem[i] = 8'(i * 5 + 1);
    do_reset;
    run(OP_INIT, 0, 0, 0, ALG_MARCH_C, 0);
    foreach (rows[r]) begin
      c = ~crc_of(rows[r][0], rows[r][1], 16'hFFFF);
      mste_mem_model_i.mem[REF] = c[7:0] ^ 8'(rows[r][2]);
      mste_mem_model_i.mem[REF + 1] = c[15:8];
      run(OP_ROMCHK, rows[r][0], rows[r][1], 0, ALG_MARCH_C, 0);
      chk(pass, rows[r][3]);
      chk(crc_result, c);
      $display("row %0d done", r);
    end
    run(OP_START, 0, 0, 0, ALG_MARCH_C, 0);
    run(OP_ACCUM, 2, 7, 0, ALG_MARCH_C, 0);
    run(OP_ACCUM, 20, 9, 0, ALG_MARCH_C, 0);
    run(OP_RESULT, 0, 0, 0, ALG_MARCH_C, 0);
    c = ~crc_of(20, 9, crc_of(2, 7, 16'hFFFF));
    chk(crc_result, c);
    {mste_mem_model_i.mem[REF + 1], mste_mem_model_i.mem[REF]} = c;
    run(OP_VERIFY, 0, 0, 0, ALG_MARCH_C, 0);
    chk(pass, 1);
    $display("checksum ranges done");
    slow = 1'b1;
    run(OP_MARCH, 32'h80, 32'h8E, 1, ALG_MARCH_C, 0);
    chk({pass, diff(8'h00, 0)}, 9'h100);
    run(OP_MARCH, 32'h80, 32'h8C, 2, ALG_MARCH_X, 0);
    chk({pass, diff(8'h55, 0)}, 9'h100);
    slow = 1'b0;
    for (int i = 128; i < 144; i++) mste_mem_model_i.mem[i] = 8'(i * 5 + 1);
    run(OP_MARCH, 32'h80, 32'h8F, 0, ALG_MARCH_C, 3);
    chk({pass, diff(8'h00, 1)}, 9'h100);
    fault_addr = 8'hC1;
    run(OP_MARCH, 32'h80, 32'h8F, 0, ALG_MARCH_C, 3);
    chk({pass, diff(8'h00, 1)}, 9'h000);
    fault_addr = 8'h84;
    run(OP_MARCH, 32'h80, 32'h8C, 2, ALG_MARCH_X, 0);
    chk(pass, 0);
    fault_addr = 8'hFF;
    run(OP_MARCH, 32'h81, 32'h8E, 1, ALG_MARCH_C, 0);
    chk(pass, 0);
    run(OP_MARCH, 32'h80, 32'h8C, 3, ALG_MARCH_C, 0);
    chk(pass, 0);
    run(OP_MARCH, 32'h8C, 32'h80, 2, ALG_MARCH_X, 0);
    chk(pass, 0);
    $display("march runs done");
    do_reset;
    chk({crc_result, busy, done, pass, mem_req, mem_rready}, 21'h00001);
    run(OP_RESULT, 0, 0, 0, ALG_MARCH_C, 0);
    chk({pass, crc_result}, 17'h00000);
    $display("reset and refusal done");
    test_done;
  end
endmodule
